// File: hw/phy_basic_mode_control.sv
// basic mode control register with serial management access
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defs.svh"

// Functional notes
// - writing one to bit 15 starts reset; reads one until done
// - reset completion reloads configuration from the strap inputs
// - loopback bit 14 sends mii transmit data into receive path
// - after loopback enable, receive data may be invalid up to 500 us
// - with negotiation off, bit 13 one means 100 Mb/s, zero 10 Mb/s
// - negotiation enable bit 12 makes speed and duplex bits ignored
// - negotiation off: manual speed and duplex bits set operation
// - negotiation enable, speed and duplex reset values come from straps
// - latched-high bit sets on event, holds until register read
// - latched-low bit drops on event, holds low until register read
// - clear-on-read field returns its value then clears to zero
// - self-setting field is set while its event lasts, then clears
// - permanent read-only field returns fixed value, ignores writes
// - bit 11 powers down; active-low pin also sets it
// - negotiation off: bit 8 one full duplex, zero half duplex

module phy_basic_mode_control #(
	parameter int DEAD_CYCLES = `DEAD_CYCLES
) (
	input  wire logic          mclk,
	input  wire logic          reset_n,
	input  wire logic          mdc,
	input  wire logic          mdio_in,
	output logic               mdio_out,
	output logic               mdio_oe,
	input  wire logic [4:0]    phy_addr,
	input  wire logic          strap_an_enable,
	input  wire logic          strap_speed_100,
	input  wire logic          strap_full_duplex,
	input  wire logic          power_down_interrupt_pin_n,
	input  wire logic          an_speed_100,
	input  wire logic          an_full_duplex,
	input  wire logic          link_ok,
	input  wire logic          remote_fault,
	input  wire logic          an_busy,
	input  wire logic          rx_err_evt,
	input  wire bmc_pkg::mii_t mii_tx,
	input  wire bmc_pkg::mii_t pcs_rx,
	output bmc_pkg::mii_t      mii_rx,
	output logic               dead_time,
	output logic               phy_soft_reset,
	output logic               power_down,
	output logic               an_enable,
	output logic               port_speed_100,
	output logic               port_full_duplex
);
	import bmc_pkg::*;

	localparam logic [7:0] SRST_LAST = 8'(`SRST_CYCLES - 1);

	// frame receiver state
	mdio_state_t state_r;
	mdio_state_t state_nxt;
	logic [4:0]  cnt_r;
	logic [4:0]  cnt_nxt;
	logic [5:0]  ones_r;
	logic [5:0]  ones_nxt;
	logic [15:0] shift_r;
	logic [15:0] shift_nxt;
	logic [4:0]  regad_r;
	logic [4:0]  regad_nxt;
	logic        rd_op_r;
	logic        rd_op_nxt;
	logic        out_r;
	logic        out_nxt;
	logic        oe_r;
	logic        oe_nxt;
	logic        mdc_q_r;
	logic        mdc_q_nxt;
	logic        rise;
	logic        wr_en;
	logic        rd_en;
	logic [11:0] hdr;
	logic [15:0] wdata;
	logic [15:0] rdata;

	// control register state
	ctrl_word_t  ctrl_r;
	ctrl_word_t  ctrl_nxt;
	ctrl_word_t  ctrl_wr;
	ctrl_word_t  ctrl_rd;
	ctrl_word_t  strap_cfg;
	logic [7:0]  srst_cnt_r;
	logic [7:0]  srst_cnt_nxt;
	logic        srst_done;

	// effective operating mode
	logic        pd_r;
	logic        pd_nxt;
	logic        spd_r;
	logic        spd_nxt;
	logic        dup_r;
	logic        dup_nxt;

	// status bits
	logic [3:0]  cell_ev;
	logic [3:0]  cell_val;
	logic        cell_rst_n;
	logic        rd_stat;
	logic [7:0]  errcnt_r;
	logic [7:0]  errcnt_nxt;
	logic [15:0] stat_word;

	localparam access_t CELL_KIND [4] = '{ACC_ROP, ACC_LATCH_LO, ACC_LATCH_HI, ACC_SELF_SET};
	localparam int      CELL_POS  [4] = '{`ST_PERM_BIT, `ST_LINK_BIT, `ST_FAULT_BIT, `ST_BUSY_BIT};

	// mdc is synchronous to mclk, so a plain edge detect is enough
	assign rise  = mdc & ~mdc_q_r;
	assign hdr   = {shift_r[10:0], mdio_in};
	assign wdata = {shift_r[14:0], mdio_in};

	// management frame receiver: preamble, start, header, turnaround, data
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		ones_nxt  = ones_r;
		shift_nxt = shift_r;
		regad_nxt = regad_r;
		rd_op_nxt = rd_op_r;
		out_nxt   = out_r;
		oe_nxt    = oe_r;
		mdc_q_nxt = mdc;
		wr_en     = 1'h0;
		rd_en     = 1'h0;
		if (rise) begin
			unique case (state_r)
				ST_IDLE: begin
					if (mdio_in) begin
						ones_nxt = (ones_r == `PRE_LEN) ? ones_r : ones_r + 6'h01;
					end else begin
						ones_nxt = 6'h00;
						if (ones_r == `PRE_LEN) begin
							state_nxt = ST_START;
						end
					end
				end
				ST_START: begin
					state_nxt = mdio_in ? ST_HDR : ST_IDLE;
					cnt_nxt   = 5'h00;
				end
				ST_HDR: begin
					shift_nxt = {shift_r[14:0], mdio_in};
					cnt_nxt   = cnt_r + 5'h01;
					if (cnt_r == `HDR_LAST) begin
						// frames for another phy or with a bad opcode are ignored
						state_nxt = ST_IDLE;
						cnt_nxt   = 5'h00;
						regad_nxt = hdr[4:0];
						rd_op_nxt = (hdr[11:10] == `OP_RD);
						if (hdr[`PHYAD_MSB:`PHYAD_LSB] == phy_addr &&
						    (hdr[11:10] == `OP_RD || hdr[11:10] == `OP_WR)) begin
							state_nxt = ST_TA;
						end
					end
				end
				ST_TA: begin
					if (rd_op_r) begin
						// second turnaround bit driven low, data snapshot taken now
						oe_nxt    = 1'h1;
						out_nxt   = 1'h0;
						shift_nxt = rdata;
						rd_en     = 1'h1;
						state_nxt = ST_DATA;
					end else begin
						cnt_nxt = cnt_r + 5'h01;
						if (cnt_r == `TA_LAST) begin
							state_nxt = ST_DATA;
							cnt_nxt   = 5'h00;
						end
					end
				end
				ST_DATA: begin
					if (rd_op_r) begin
						if (cnt_r == `DATA_BITS) begin
							oe_nxt    = 1'h0;
							state_nxt = ST_IDLE;
						end else begin
							out_nxt   = shift_r[15];
							shift_nxt = {shift_r[14:0], 1'h0};
							cnt_nxt   = cnt_r + 5'h01;
						end
					end else begin
						shift_nxt = wdata;
						cnt_nxt   = cnt_r + 5'h01;
						if (cnt_r == `DATA_LAST) begin
							wr_en     = 1'h1;
							state_nxt = ST_IDLE;
						end
					end
				end
			endcase
		end
		if (!reset_n) begin
			state_nxt = ST_IDLE;
			cnt_nxt   = 5'h00;
			ones_nxt  = 6'h00;
			shift_nxt = 16'h0000;
			regad_nxt = 5'h00;
			rd_op_nxt = 1'h0;
			out_nxt   = 1'h0;
			oe_nxt    = 1'h0;
			mdc_q_nxt = 1'h1; // mdc idles high, so no false rise after reset
		end
	end

	always_ff @(posedge mclk) begin
		state_r <= state_nxt;
		cnt_r   <= cnt_nxt;
		ones_r  <= ones_nxt;
		shift_r <= shift_nxt;
		regad_r <= regad_nxt;
		rd_op_r <= rd_op_nxt;
		out_r   <= out_nxt;
		oe_r    <= oe_nxt;
		mdc_q_r <= mdc_q_nxt;
	end

	assign mdio_out = out_r;
	assign mdio_oe  = oe_r;

	// strap image used at hardware reset and at soft reset completion
	always_comb begin
		strap_cfg             = '0;
		strap_cfg.an_enable   = strap_an_enable;
		strap_cfg.speed_100   = strap_speed_100;
		strap_cfg.full_duplex = strap_full_duplex;
	end

	// control register: writes, soft reset timer and strap reload
	always_comb begin
		ctrl_nxt     = ctrl_r;
		srst_cnt_nxt = srst_cnt_r;
		srst_done    = 1'h0;
		ctrl_wr      = ctrl_word_t'(wdata);
		if (ctrl_r.soft_reset) begin
			srst_cnt_nxt = srst_cnt_r + 8'h01;
			srst_done    = (srst_cnt_r == SRST_LAST);
		end
		// writes while a reset runs are dropped, the reload would undo them
		if (wr_en && regad_r == `REG_CTRL && !ctrl_r.soft_reset) begin
			ctrl_nxt.soft_reset  = ctrl_wr.soft_reset;
			ctrl_nxt.loopback    = ctrl_wr.loopback;
			ctrl_nxt.speed_100   = ctrl_wr.speed_100;
			ctrl_nxt.an_enable   = ctrl_wr.an_enable;
			ctrl_nxt.power_down  = ctrl_wr.power_down;
			ctrl_nxt.isolate     = ctrl_wr.isolate;
			ctrl_nxt.full_duplex = ctrl_wr.full_duplex;
			ctrl_nxt.col_test    = ctrl_wr.col_test;
			srst_cnt_nxt         = 8'h00;
		end
		if (!reset_n || srst_done) begin
			ctrl_nxt     = strap_cfg;
			srst_cnt_nxt = 8'h00;
		end
	end

	always_ff @(posedge mclk) begin
		ctrl_r     <= ctrl_nxt;
		srst_cnt_r <= srst_cnt_nxt;
	end

	// read image: pin folded into power down, reserved bits read zero
	always_comb begin
		ctrl_rd            = ctrl_r;
		ctrl_rd.power_down = ctrl_r.power_down | ~power_down_interrupt_pin_n;
		ctrl_rd.restart_an = 1'h0;
		ctrl_rd.rsvd       = 7'h00;
	end

	// operating mode: negotiated result wins while negotiation is enabled
	always_comb begin
		pd_nxt  = ctrl_rd.power_down;
		spd_nxt = ctrl_r.an_enable ? an_speed_100 : ctrl_r.speed_100;
		dup_nxt = ctrl_r.an_enable ? an_full_duplex : ctrl_r.full_duplex;
		if (!reset_n) begin
			pd_nxt  = 1'h0;
			spd_nxt = 1'h0;
			dup_nxt = 1'h0;
		end
	end

	always_ff @(posedge mclk) begin
		pd_r  <= pd_nxt;
		spd_r <= spd_nxt;
		dup_r <= dup_nxt;
	end

	assign phy_soft_reset   = ctrl_r.soft_reset;
	assign an_enable        = ctrl_r.an_enable;
	assign power_down       = pd_r;
	assign port_speed_100   = spd_r;
	assign port_full_duplex = dup_r;

	// status bits: soft reset clears the latches as a hard reset does
	assign cell_rst_n = reset_n & ~srst_done;
	assign rd_stat    = rd_en && (regad_r == `REG_STAT);
	assign cell_ev    = {an_busy, remote_fault, ~link_ok, 1'h0};

	for (genvar g = 0; g < 4; g++) begin : g_cell
		status_cell #(
			.KIND (CELL_KIND[g]),
			.PERM (1'h1)
		) u_cell (
			.mclk       (mclk),
			.reset_n    (cell_rst_n),
			.event_in   (cell_ev[g]),
			.read_pulse (rd_stat),
			.value      (cell_val[g])
		);
	end

	// error counter: a read returns the count and clears it, a new error wins
	always_comb begin
		errcnt_nxt = errcnt_r;
		if (rd_stat) begin
			errcnt_nxt = 8'h00;
		end
		if (rx_err_evt) begin
			errcnt_nxt = rd_stat ? 8'h01 : ((errcnt_r == `ERRCNT_MAX) ? errcnt_r : errcnt_r + 8'h01);
		end
		if (!cell_rst_n) begin
			errcnt_nxt = 8'h00;
		end
	end

	always_ff @(posedge mclk) begin
		errcnt_r <= errcnt_nxt;
	end

	// read data mux; unmapped addresses read zero
	always_comb begin
		stat_word = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			stat_word[CELL_POS[i]] = cell_val[i];
		end
		stat_word[`ST_CNT_MSB:`ST_CNT_LSB] = errcnt_r;
		unique case (regad_r)
			`REG_CTRL: rdata = 16'(ctrl_rd);
			`REG_STAT: rdata = stat_word;
			default:   rdata = 16'h0000;
		endcase
	end

	// data path with the loopback switch and its dead time
	loopback_path #(
		.DEAD_CYCLES (DEAD_CYCLES)
	) u_loop (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.loop_en   (ctrl_r.loopback),
		.mii_tx    (mii_tx),
		.pcs_rx    (pcs_rx),
		.mii_rx    (mii_rx),
		.dead_time (dead_time)
	);

endmodule : phy_basic_mode_control
`default_nettype wire

// File: hw/bmc_defs.svh
// constants for the basic mode control register bank
`ifndef BMC_DEFS_SVH
`define BMC_DEFS_SVH

// management register addresses
`define REG_CTRL      5'h00
`define REG_STAT      5'h01
`define PHYAD_MSB     9
`define PHYAD_LSB     5

// management frame layout
`define OP_RD         2'h2
`define OP_WR         2'h1
`define PRE_LEN       6'h20
`define HDR_LAST      5'h0B
`define TA_LAST       5'h01
`define DATA_BITS     5'h10
`define DATA_LAST     5'h0F

// status word layout
`define ST_PERM_BIT   0
`define ST_LINK_BIT   2
`define ST_FAULT_BIT  4
`define ST_BUSY_BIT   5
`define ST_CNT_LSB    8
`define ST_CNT_MSB    15
`define ERRCNT_MAX    8'hFF

// timing
`define CLK_NS        5
`define SRST_TIME_NS  1000
`define SRST_CYCLES   ((`SRST_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`define DEAD_TIME_US  500
`define DEAD_CYCLES   ((`DEAD_TIME_US * 1000) / `CLK_NS)

`endif

// File: hw/bmc_pkg.sv
// types shared by the basic mode control register bank
package bmc_pkg;

	// access behaviour of one status bit
	typedef enum logic [3:0] {
		ACC_LATCH_HI = 4'h1,
		ACC_LATCH_LO = 4'h2,
		ACC_SELF_SET = 4'h4,
		ACC_ROP      = 4'h8
	} access_t;

	// management frame receiver states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_START = 5'h02,
		ST_HDR   = 5'h04,
		ST_TA    = 5'h08,
		ST_DATA  = 5'h10
	} mdio_state_t;

	// basic mode control word, msb first
	typedef struct packed {
		logic       soft_reset;
		logic       loopback;
		logic       speed_100;
		logic       an_enable;
		logic       power_down;
		logic       isolate;
		logic       restart_an;
		logic       full_duplex;
		logic       col_test;
		logic [6:0] rsvd;
	} ctrl_word_t;

	// one mii nibble with its qualifiers
	typedef struct packed {
		logic       en;
		logic       er;
		logic [3:0] d;
	} mii_t;

endpackage : bmc_pkg

// File: hw/status_cell.sv
// one status bit with a selectable access behaviour
`timescale 1ns/1ps
`default_nettype none

module status_cell #(
	parameter bmc_pkg::access_t KIND = bmc_pkg::ACC_LATCH_HI,
	parameter logic             PERM = 1'h0
) (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic event_in,
	input  wire logic read_pulse,
	output logic      value
);
	import bmc_pkg::*;

	logic val_r;
	logic val_nxt;

	// event beats a read in the same cycle so nothing is lost
	always_comb begin
		val_nxt = val_r;
		unique case (KIND)
			ACC_LATCH_HI: val_nxt = event_in ? 1'h1 : (read_pulse ? 1'h0 : val_r);
			ACC_LATCH_LO: val_nxt = event_in ? 1'h0 : (read_pulse ? 1'h1 : val_r);
			ACC_SELF_SET: val_nxt = event_in;
			ACC_ROP: val_nxt = PERM;
		endcase
		if (!reset_n) begin
			val_nxt = (KIND == ACC_ROP) ? PERM : 1'h0;
		end
	end

	always_ff @(posedge mclk) begin
		val_r <= val_nxt;
	end

	assign value = val_r;

endmodule : status_cell
`default_nettype wire

// File: hw/loopback_path.sv
// receive path select with loopback dead time
`timescale 1ns/1ps
`default_nettype none

module loopback_path #(
	parameter int DEAD_CYCLES = 1
) (
	input  wire logic          mclk,
	input  wire logic          reset_n,
	input  wire logic          loop_en,
	input  wire bmc_pkg::mii_t mii_tx,
	input  wire bmc_pkg::mii_t pcs_rx,
	output bmc_pkg::mii_t      mii_rx,
	output logic               dead_time
);
	import bmc_pkg::*;

	localparam logic [16:0] DEAD_LOAD = 17'(DEAD_CYCLES);

	logic        loop_q_r;
	logic        loop_q_nxt;
	logic [16:0] dead_r;
	logic [16:0] dead_nxt;
	mii_t        rx_r;
	mii_t        rx_nxt;

	// enabling loopback starts a window where receive data is held idle
	always_comb begin
		loop_q_nxt = loop_en;
		dead_nxt   = dead_r;
		if (!loop_en) begin
			dead_nxt = 17'h00000;
		end else if (!loop_q_r) begin
			dead_nxt = DEAD_LOAD;
		end else if (dead_r != 17'h00000) begin
			dead_nxt = dead_r - 17'h00001;
		end
		rx_nxt = loop_en ? mii_tx : pcs_rx;
		if (dead_nxt != 17'h00000) begin
			rx_nxt = '0; // descrambler relock, no valid data
		end
		if (!reset_n) begin
			loop_q_nxt = 1'h0;
			dead_nxt   = 17'h00000;
			rx_nxt     = '0;
		end
	end

	always_ff @(posedge mclk) begin
		loop_q_r <= loop_q_nxt;
		dead_r   <= dead_nxt;
		rx_r     <= rx_nxt;
	end

	assign mii_rx    = rx_r;
	assign dead_time = (dead_r != 17'h00000);

endmodule : loopback_path
`default_nettype wire

// File: tb/phy_basic_mode_control_sva.sv
// assertions on the ports of the basic mode control register bank
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defs.svh"

module bmc_checker #(
	parameter int DEAD_CYCLES = 1
) (
	input wire logic          mclk,
	input wire logic          reset_n,
	input wire logic          strap_an_enable,
	input wire logic          power_down_interrupt_pin_n,
	input wire logic          an_speed_100,
	input wire logic          an_full_duplex,
	input wire bmc_pkg::mii_t mii_tx,
	input wire bmc_pkg::mii_t mii_rx,
	input wire logic          dead_time,
	input wire logic          phy_soft_reset,
	input wire logic          power_down,
	input wire logic          an_enable,
	input wire logic          port_speed_100
);
	import bmc_pkg::*;
	int scnt_r, scnt_nxt, dcnt_r, dcnt_nxt;

	// run lengths of soft reset and dead window, too long for a repetition
	always_comb begin
		scnt_nxt = phy_soft_reset ? scnt_r + 32'h1 : 32'h0;
		dcnt_nxt = dead_time ? dcnt_r + 32'h1 : 32'h0;
	end
	always_ff @(posedge mclk) begin
		scnt_r <= reset_n ? scnt_nxt : 32'h0;
		dcnt_r <= reset_n ? dcnt_nxt : 32'h0;
	end

	default clocking @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	a_srst_len: assert property ($fell(phy_soft_reset) |-> scnt_r == `SRST_CYCLES)
		else $error("soft reset length wrong");
	a_srst_strap: assert property ($fell(phy_soft_reset) |-> ##[0:2] an_enable == strap_an_enable)
		else $error("strap not reloaded after soft reset");
	a_reset_strap: assert property ($rose(reset_n) |-> ##[0:2] an_enable == strap_an_enable)
		else $error("strap not loaded at reset");
	a_an_follow: assert property ($past(reset_n) && $past(an_enable) |->
		port_speed_100 == $past(an_speed_100))
		else $error("negotiated speed not used");
	a_pin_pd: assert property (!power_down_interrupt_pin_n ##1 !power_down_interrupt_pin_n |-> power_down)
		else $error("pin did not power down");
	a_dead_zero: assert property (dead_time && $past(dead_time) |-> mii_rx == 6'h00)
		else $error("receive data during dead window");
	a_dead_len: assert property ($fell(dead_time) |-> dcnt_r == DEAD_CYCLES)
		else $error("dead window length wrong");
	a_loop_path: assert property ($fell(dead_time) |-> ##1 mii_rx == $past(mii_tx))
		else $error("transmit data not looped back");

	c_srst: cover property ($fell(phy_soft_reset));
	c_dead: cover property ($fell(dead_time));
	c_pin: cover property (!power_down_interrupt_pin_n && power_down);
endmodule : bmc_checker

bind phy_basic_mode_control bmc_checker #(.DEAD_CYCLES(DEAD_CYCLES)) chk_i (.mclk, .reset_n, .strap_an_enable,
	.power_down_interrupt_pin_n, .an_speed_100, .an_full_duplex, .mii_tx, .mii_rx, .dead_time, .phy_soft_reset,
	.power_down, .an_enable, .port_speed_100);
`default_nettype wire

// File: tb/mgmt_master.sv
// station management controller model sending serial management frames
`timescale 1ns/1ps
`default_nettype none

module mgmt_master (
	input  wire logic mclk,
	input  wire logic mdio_wire,
	output logic      mdc,
	output logic      m_out,
	output logic      m_oe
);
	// mdc stands high between frames, line released to its pull-up
	initial begin
		mdc = 1'b1;
		m_out = 1'b1;
		m_oe = 1'b0;
	end

	// one mdc period of four mclk; the line is sampled just before the rise
	task automatic bit_cyc(input logic b, input logic en, output logic smp);
		m_oe = en;
		m_out = b;
		mdc = 1'b0;
		repeat (2) @(negedge mclk);
		smp = mdio_wire;
		mdc = 1'b1;
		repeat (2) @(negedge mclk);
	endtask : bit_cyc

	// whole frame, full preamble every time, msb first
	task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rdat);
		logic [45:0] hdr;
		logic        s;
		rdat = 16'h0000;
		hdr = {32'hFFFFFFFF, 2'b01, (rd ? 2'b10 : 2'b01), pa, ra};
		for (int i = 45; i >= 0; i--) bit_cyc(hdr[i], 1'b1, s);
		if (rd) begin
			// released line; bit 15 is seen before the third rise
			for (int k = 1; k <= 18; k++) begin
				bit_cyc(1'b1, 1'b0, s);
				if (k >= 3) rdat[18-k] = s;
			end
		end else begin
			for (int i = 17; i >= 0; i--) bit_cyc(((i > 15) ? (i == 17) : wd[i]), 1'b1, s);
		end
		m_oe = 1'b0;
	endtask : xfer
endmodule : mgmt_master
`default_nettype wire

// File: tb/phy_basic_mode_control_tb.sv
// self-checking bench for the basic mode control register bank
`timescale 1ns/1ps
`default_nettype none

module phy_basic_mode_control_tb;
	import bmc_pkg::*;
	localparam logic [4:0] PA = 5'h03;
	logic        mclk, reset_n, mdc, m_out, m_oe, mdio_out, mdio_oe, mdio_wire;
	logic        st_an, st_spd, st_dup, pin_n, an_spd, an_dup, link_ok, fault, an_busy, rx_err;
	logic        dead_time, srst, pd, an_en, p_spd, p_dup;
	mii_t        mii_tx, pcs_rx, mii_rx;
	logic [15:0] rd;
	int          fails, comparisons;

	// wire level with the pull-up when nobody drives
	assign mdio_wire = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1);
	always #2.5 mclk = ~mclk;

	phy_basic_mode_control #(.DEAD_CYCLES(8)) dut (.mclk, .reset_n, .mdc, .mdio_in(mdio_wire), .mdio_out,
		.mdio_oe, .phy_addr(PA), .strap_an_enable(st_an), .strap_speed_100(st_spd), .strap_full_duplex(st_dup),
		.power_down_interrupt_pin_n(pin_n), .an_speed_100(an_spd), .an_full_duplex(an_dup), .link_ok,
		.remote_fault(fault), .an_busy, .rx_err_evt(rx_err), .mii_tx, .pcs_rx, .mii_rx, .dead_time,
		.phy_soft_reset(srst), .power_down(pd), .an_enable(an_en), .port_speed_100(p_spd),
		.port_full_duplex(p_dup));

	mgmt_master mm (.mclk, .mdio_wire, .mdc, .m_out, .m_oe);

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		mm.xfer(1'b0, PA, ra, d, rd);
	endtask : wr

	task automatic rdr(input logic [4:0] ra, input logic [15:0] exp);
		mm.xfer(1'b1, PA, ra, 16'h0000, rd);
		chk(rd, exp);
	endtask : rdr

	task automatic print_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	// watchdog, about eight times the expected run
	initial begin
		#200000;
		fails++;
		$display("ERROR at %0t: watchdog expired", $time);
		print_verdict();
	end

	initial begin
		mclk = 1'b0;
		reset_n = 1'b0;
		{st_an, st_spd, st_dup, pin_n, an_spd, an_dup} = 6'h35; // pin released, negotiated 10 full
		{link_ok, fault, an_busy, rx_err} = 4'h8;
		mii_tx = 6'h25;
		pcs_rx = 6'h1A;
		repeat (10) @(negedge mclk);
		reset_n = 1'b1;
		@(negedge mclk);
		rdr(5'h00, 16'h3000);
		chk({14'h0000, p_spd, p_dup}, 16'h0001);
		$display("test straps done");

		// manual mode; restart and reserved bits must not stick
		wr(5'h00, 16'h237F);
		rdr(5'h00, 16'h2100);
		chk({13'h0000, an_en, p_spd, p_dup}, 16'h0003);
		wr(5'h00, 16'h0000);
		repeat (2) @(negedge mclk);
		chk({14'h0000, p_spd, p_dup}, 16'h0000);
		mm.xfer(1'b0, PA ^ 5'h01, 5'h00, 16'h2100, rd);
		rdr(5'h00, 16'h0000);
		rdr(5'h05, 16'h0000);
		$display("test manual mode done");

		wr(5'h00, 16'h0800);
		chk({15'h0000, pd}, 16'h0001);
		wr(5'h00, 16'h0000);
		pin_n = 1'b0;
		repeat (2) @(negedge mclk);
		rdr(5'h00, 16'h0800);
		pin_n = 1'b1;
		$display("test power down done");

		// status word: link, fault and error events come and go before the read, busy stays high
		mm.xfer(1'b1, PA, 5'h01, 16'h0000, rd);
		{link_ok, fault, an_busy} = 3'h3;
		repeat (3) begin
			@(negedge mclk) rx_err = 1'b1;
			@(negedge mclk) rx_err = 1'b0;
		end
		{link_ok, fault} = 2'h2;
		rdr(5'h01, 16'h0331);
		an_busy = 1'b0;
		wr(5'h01, 16'hFFFF);
		rdr(5'h01, 16'h0005);
		$display("test status done");

		wr(5'h00, 16'h4000);
		chk({9'h000, dead_time, mii_rx}, 16'h0040);
		repeat (10) @(negedge mclk);
		chk({10'h000, mii_rx}, 16'h0025);
		wr(5'h00, 16'h0000);
		repeat (2) @(negedge mclk);
		chk({10'h000, mii_rx}, 16'h001A);
		$display("test loopback done");

		{st_an, st_spd, st_dup} = 3'h1;
		wr(5'h00, 16'h8000);
		chk({15'h0000, srst}, 16'h0001);
		rdr(5'h00, 16'h8000);
		for (int i = 0; i < 300 && srst !== 1'b0; i++) @(negedge mclk);
		chk({15'h0000, srst}, 16'h0000);
		rdr(5'h00, 16'h0100);
		chk({13'h0000, an_en, p_spd, p_dup}, 16'h0001);
		$display("test soft reset done");
		print_verdict();
	end
endmodule : phy_basic_mode_control_tb
`default_nettype wire
